// ---- rtl/vout_monitor_pkg.sv ----
// Constants for the output-voltage fault monitor: command codes, field layout,
// reset values and hiccup timing.
// Assumes a 125 MHz system clock and Ulinear16 voltage codes compared as unsigned.
package vout_monitor_pkg;

    localparam int VOLT_W = 16;
    localparam int CMD_W  = 8;
    localparam int ACT_W  = 8;

    // Command codes of the four limit and response registers
    localparam logic [CMD_W-1:0] CMD_OV_WARN   = 8'h42;
    localparam logic [CMD_W-1:0] CMD_UV_WARN   = 8'h43;
    localparam logic [CMD_W-1:0] CMD_UV_FAULT  = 8'h44;
    localparam logic [CMD_W-1:0] CMD_UV_ACTION = 8'h45;

    // Fault-action byte layout
    localparam int ACT_MODE_HI  = 7;
    localparam int ACT_MODE_LO  = 6;
    localparam int ACT_RETRY_HI = 5;
    localparam int ACT_RETRY_LO = 3;
    localparam int ACT_DELAY_HI = 2;
    localparam int ACT_DELAY_LO = 0;

    localparam logic [1:0] MODE_HICCUP  = 2'b10;
    localparam logic [1:0] MODE_LATCH   = 2'b11;
    localparam logic [2:0] RETRY_FOREVER = 3'b111;

    // Reset values: warnings and fault disarmed, hiccup once with one unit of off time
    localparam logic [VOLT_W-1:0] RST_OV_WARN   = 16'hffff;
    localparam logic [VOLT_W-1:0] RST_UV_WARN   = 16'h0000;
    localparam logic [VOLT_W-1:0] RST_UV_FAULT  = 16'h0000;
    localparam logic [ACT_W-1:0]  RST_UV_ACTION = 8'h80;

    // Hiccup off-time unit
    localparam int CLK_PERIOD_NS  = 8;
    localparam int HICCUP_UNIT_MS = 100;
    localparam int HICCUP_UNIT_CYCLES = HICCUP_UNIT_MS * 1000000 / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        ST_RUN      = 2'b00,
        ST_HICCUP   = 2'b01,
        ST_RESTART  = 2'b11,
        ST_LATCHED  = 2'b10
    } mon_state_e;

endpackage : vout_monitor_pkg

// ---- rtl/vout_fault_monitor.sv ----
// Output-voltage supervision: warning and under-voltage fault detection,
// alert line, hiccup retry and latch-off response.
// Assumes vout_i, soft_start_done_i and the command strobes are synchronous to clk_i;
// cycling input power is seen here as sys_rst_i.
//
// Summary of operation
// - Output above over-voltage warning threshold pulls alert low and holds it.
// - Output below under-voltage warning threshold pulls alert low and holds it.
// - Under-voltage fault is checked only once soft-start has finished.
// - Under-voltage fault pulls alert low, holds it, and runs selected action.
// - Action mode 10 turns output off, then retries per retry-count field.
// - Action mode 11 latches output off with no automatic restart.
// - Latch-off clears by control enable, turn-on command, or power cycle.
// - Retry codes 0 to 6 give 1 to 64 attempts, then output shuts off.
// - Retry code 7 keeps retrying until the fault is gone.
// - A restart that completes without fault returns to normal operation.
// - Off time between hiccups is 2 to the n units of 100 ms.
`timescale 1ns/1ps
module vout_fault_monitor
#(
    parameter int unsigned UNIT_CYCLES = vout_monitor_pkg::HICCUP_UNIT_CYCLES
)
(
    input  wire logic                                clk_i,
    input  wire logic                                sys_rst_i,
    input  wire logic [vout_monitor_pkg::VOLT_W-1:0] vout_i,
    input  wire logic                                soft_start_done_i,
    input  wire logic                                ctrl_enable_i,
    input  wire logic                                operation_on_i,
    input  wire logic                                alert_clear_i,
    input  wire logic                                cmd_wr_i,
    input  wire logic                                cmd_rd_i,
    input  wire logic [vout_monitor_pkg::CMD_W-1:0]  cmd_code_i,
    input  wire logic [vout_monitor_pkg::VOLT_W-1:0] cmd_wdata_i,
    output logic      [vout_monitor_pkg::VOLT_W-1:0] cmd_rdata_o,
    output logic                                     cmd_rvalid_o,
    output logic                                     fault_alert_n_o,
    output logic                                     output_enable_o,
    output logic                                     fault_latched_o,
    output logic                                     hiccup_active_o
);
    import vout_monitor_pkg::*;

    typedef struct packed {
        mon_state_e        state;
        logic [VOLT_W-1:0] ov_warn;
        logic [VOLT_W-1:0] uv_warn;
        logic [VOLT_W-1:0] uv_fault;
        logic [ACT_W-1:0]  action;
        logic [6:0]        attempts;
        logic [31:0]       unit_cnt;
        logic [7:0]        units_left;
        logic              ctrl_prev;
        logic              alert_n;
        logic              out_en;
        logic [VOLT_W-1:0] rdata;
        logic              rvalid;
        logic              latched;
        logic              hiccup;
    } mon_s;

    mon_s st;
    mon_s next_st;

    logic [1:0] mode;
    logic [2:0] retry_code;
    logic [7:0] retry_limit;
    logic       uv_check;
    logic       uv_fault_now;
    logic       warn_now;
    logic       latch_clear;

    always_comb
    begin
        mode         = st.action[ACT_MODE_HI:ACT_MODE_LO];
        retry_code   = st.action[ACT_RETRY_HI:ACT_RETRY_LO];
        retry_limit  = 8'h01 << retry_code;
        uv_check     = st.out_en && soft_start_done_i;
        uv_fault_now = uv_check && (vout_i < st.uv_fault);
        warn_now     = (vout_i > st.ov_warn) || (vout_i < st.uv_warn);
        latch_clear  = (ctrl_enable_i && !st.ctrl_prev) || operation_on_i;

        next_st           = st;
        next_st.ctrl_prev = ctrl_enable_i;
        next_st.rvalid    = cmd_rd_i;

        if (cmd_wr_i)
        begin
            if (cmd_code_i == CMD_OV_WARN)
                next_st.ov_warn = cmd_wdata_i;
            else if (cmd_code_i == CMD_UV_WARN)
                next_st.uv_warn = cmd_wdata_i;
            else if (cmd_code_i == CMD_UV_FAULT)
                next_st.uv_fault = cmd_wdata_i;
            else if (cmd_code_i == CMD_UV_ACTION)
                next_st.action = cmd_wdata_i[ACT_W-1:0];
        end

        if (cmd_rd_i)
        begin
            if (cmd_code_i == CMD_OV_WARN)
                next_st.rdata = st.ov_warn;
            else if (cmd_code_i == CMD_UV_WARN)
                next_st.rdata = st.uv_warn;
            else if (cmd_code_i == CMD_UV_FAULT)
                next_st.rdata = st.uv_fault;
            else if (cmd_code_i == CMD_UV_ACTION)
                next_st.rdata = {8'h00, st.action};
            else
                next_st.rdata = 16'h0000;
        end

        case (st.state)
            ST_RUN:
            begin
                if (uv_fault_now && mode == MODE_HICCUP)
                begin
                    next_st.state      = ST_HICCUP;
                    next_st.units_left = 8'h01 << st.action[ACT_DELAY_HI:ACT_DELAY_LO];
                    next_st.unit_cnt   = UNIT_CYCLES - 1;
                end
                else if (uv_fault_now && mode == MODE_LATCH)
                    next_st.state = ST_LATCHED;
            end
            ST_HICCUP:
            begin
                if (!ctrl_enable_i)
                begin
                    // Host turned the output off: abandon the retry sequence
                    next_st.state    = ST_RUN;
                    next_st.attempts = 7'h00;
                end
                else if (st.unit_cnt == 32'h0000_0000)
                begin
                    next_st.unit_cnt = UNIT_CYCLES - 1;
                    if (st.units_left == 8'h01)
                        next_st.state = ST_RESTART;
                    else
                        next_st.units_left = st.units_left - 8'h01;
                end
                else
                    next_st.unit_cnt = st.unit_cnt - 32'h0000_0001;
            end
            ST_RESTART:
            begin
                if (uv_fault_now)
                begin
                    if (retry_code == RETRY_FOREVER ||
                        {1'b0, st.attempts} + 8'h01 < retry_limit)
                    begin
                        next_st.state      = ST_HICCUP;
                        next_st.attempts   = st.attempts + 7'h01;
                        next_st.units_left = 8'h01 << st.action[ACT_DELAY_HI:ACT_DELAY_LO];
                        next_st.unit_cnt   = UNIT_CYCLES - 1;
                    end
                    else
                        next_st.state = ST_LATCHED;
                end
                else if (uv_check)
                begin
                    next_st.state    = ST_RUN;
                    next_st.attempts = 7'h00;
                end
                else if (!ctrl_enable_i)
                begin
                    next_st.state    = ST_RUN;
                    next_st.attempts = 7'h00;
                end
            end
            default:
            begin
                if (latch_clear)
                begin
                    next_st.state    = ST_RUN;
                    next_st.attempts = 7'h00;
                end
            end
        endcase

        // A new warning or fault in the clearing cycle keeps the line low
        if (warn_now || uv_fault_now)
            next_st.alert_n = 1'b0;
        else if (alert_clear_i || latch_clear)
            next_st.alert_n = 1'b1;

        next_st.out_en = ctrl_enable_i &&
                         (next_st.state == ST_RUN || next_st.state == ST_RESTART);
        // Status pins come from their own flops, not from a state decode
        next_st.latched = (next_st.state == ST_LATCHED);
        next_st.hiccup  = (next_st.state == ST_HICCUP);
    end

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            st            <= '0;
            st.state      <= ST_RUN;
            st.ov_warn    <= RST_OV_WARN;
            st.uv_warn    <= RST_UV_WARN;
            st.uv_fault   <= RST_UV_FAULT;
            st.action     <= RST_UV_ACTION;
            st.alert_n    <= 1'b1;
            // Enable idles high; a low history here would fake a clearing edge
            st.ctrl_prev  <= 1'b1;
        end
        else
            st <= next_st;
    end

    assign cmd_rdata_o     = st.rdata;
    assign cmd_rvalid_o    = st.rvalid;
    assign fault_alert_n_o = st.alert_n;
    assign output_enable_o = st.out_en;
    assign fault_latched_o = st.latched;
    assign hiccup_active_o = st.hiccup;

    a_ov_warn_alert: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (vout_i > st.ov_warn) |=> !fault_alert_n_o)
        else $error("over-voltage warning did not pull alert low");

    a_uv_warn_alert: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (vout_i < st.uv_warn) ##1 !alert_clear_i |-> !fault_alert_n_o ##1 1'b1)
        else $error("under-voltage warning did not pull alert low");

    a_no_early_check: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (st.state == ST_RUN && !soft_start_done_i) |=> st.state == ST_RUN)
        else $error("under-voltage fault declared before soft-start end");

    a_uv_fault_alert: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        uv_fault_now |=> !fault_alert_n_o)
        else $error("under-voltage fault did not pull alert low");

    a_hiccup_entry: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (st.state == ST_RUN && uv_fault_now && mode == MODE_HICCUP)
        |=> (st.state == ST_HICCUP && !output_enable_o))
        else $error("hiccup mode did not turn output off");

    a_latch_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (st.state == ST_LATCHED && !latch_clear) |=> (fault_latched_o && !output_enable_o))
        else $error("latched fault restarted on its own");

    a_latch_clear: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (st.state == ST_LATCHED && operation_on_i) |=> (st.state == ST_RUN && !fault_latched_o))
        else $error("turn-on command did not clear latched fault");

    a_retry_exhaust: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (st.state == ST_RESTART && uv_fault_now && retry_code != RETRY_FOREVER &&
         {1'b0, st.attempts} + 8'h01 >= retry_limit) |=> st.state == ST_LATCHED)
        else $error("retries exhausted without shutting off");

    a_retry_forever: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (st.state == ST_RESTART && uv_fault_now && retry_code == RETRY_FOREVER)
        |=> st.state == ST_HICCUP)
        else $error("endless retry mode stopped retrying");

    a_restart_ok: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (st.state == ST_RESTART && uv_check && !uv_fault_now)
        |=> (st.state == ST_RUN && st.attempts == 7'h00))
        else $error("clean restart did not return to normal");

    a_off_time: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (st.state == ST_HICCUP && ctrl_enable_i &&
         (st.units_left != 8'h01 || st.unit_cnt != 32'h0000_0000)) |=> st.state == ST_HICCUP)
        else $error("hiccup off time ended early");

endmodule : vout_fault_monitor

// ---- verification/pmbus_host_model.sv ----
// Host side of the management bus: register writes, reads and the turn-on command.
// Assumes the monitor takes strobes on the rising edge of clk_i.
`timescale 1ns/1ps
module pmbus_host_model
(
    input  wire logic        clk_i,
    output logic             cmd_wr_o,
    output logic             cmd_rd_o,
    output logic [7:0]       cmd_code_o,
    output logic [15:0]      cmd_wdata_o,
    output logic             operation_on_o,
    input  wire logic [15:0] cmd_rdata_i,
    input  wire logic        cmd_rvalid_i
);
    initial
    begin
        cmd_wr_o       = 1'b0;
        cmd_rd_o       = 1'b0;
        cmd_code_o     = 8'h00;
        cmd_wdata_o    = 16'h0000;
        operation_on_o = 1'b0;
    end

    task automatic wr(input logic [7:0] code, input logic [15:0] data);
        @(negedge clk_i);
        cmd_code_o  = code;
        cmd_wdata_o = data;
        cmd_wr_o    = 1'b1;
        @(negedge clk_i);
        cmd_wr_o    = 1'b0;
        // Released lines must not keep showing the last value
        cmd_code_o  = ~code;
        cmd_wdata_o = ~data;
    endtask : wr

    task automatic rd(input logic [7:0] code, output logic [15:0] data, output logic valid);
        @(negedge clk_i);
        cmd_code_o = code;
        cmd_rd_o   = 1'b1;
        @(negedge clk_i);
        // The answer stands for one cycle only, right after the strobe edge
        valid      = cmd_rvalid_i;
        data       = cmd_rdata_i;
        cmd_rd_o   = 1'b0;
        cmd_code_o = ~code;
    endtask : rd

    task automatic turn_on();
        @(negedge clk_i);
        operation_on_o = 1'b1;
        @(negedge clk_i);
        operation_on_o = 1'b0;
    endtask : turn_on
endmodule : pmbus_host_model

// ---- verification/vout_fault_monitor_tb.sv ----
// Testbench of the output-voltage fault monitor: registers, warnings, latch-off, hiccup.
// Assumes the host model beside it and a hiccup unit shortened to 4 cycles.
`timescale 1ns/1ps
module vout_fault_monitor_tb;
    import vout_monitor_pkg::*;
    localparam int UNIT = 4;
    logic              clk = 0;
    logic              rst = 1;
    logic [15:0]       vout = 16'h2000;
    logic              ss_done = 0;
    logic              ctrl_en = 1;
    logic              a_clr = 0;
    logic              wr, rd, rvalid, op_on, alert_n, oe, latched, hic;
    logic [7:0]        code;
    logic [15:0]       wdata, rdata;
    int                error_cnt = 0;
    int                n_checks = 0;

    initial
    begin
        forever #4 clk = ~clk;
    end

    pmbus_host_model pmbus_host_model_inst (.clk_i(clk), .cmd_wr_o(wr), .cmd_rd_o(rd),
        .cmd_code_o(code), .cmd_wdata_o(wdata), .operation_on_o(op_on),
        .cmd_rdata_i(rdata), .cmd_rvalid_i(rvalid));
    vout_fault_monitor #(.UNIT_CYCLES(UNIT)) vout_fault_monitor_inst (.clk_i(clk),
        .sys_rst_i(rst), .vout_i(vout), .soft_start_done_i(ss_done), .ctrl_enable_i(ctrl_en),
        .operation_on_i(op_on), .alert_clear_i(a_clr), .cmd_wr_i(wr), .cmd_rd_i(rd),
        .cmd_code_i(code), .cmd_wdata_i(wdata), .cmd_rdata_o(rdata), .cmd_rvalid_o(rvalid),
        .fault_alert_n_o(alert_n), .output_enable_o(oe), .fault_latched_o(latched),
        .hiccup_active_o(hic));

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic complete_run();
        $display("Checks %0d, mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : complete_run

    task automatic test_regs();
        logic [15:0] exp [5] = '{RST_OV_WARN, RST_UV_WARN, RST_UV_FAULT,
                                 {8'h00, RST_UV_ACTION}, 16'h0000};
        logic [15:0] d;
        logic        v;
        pmbus_host_model_inst.wr(8'h46, 16'h5555);
        for (int k = 0; k < 5; k++)
        begin
            pmbus_host_model_inst.rd(8'(8'h42 + k), d, v);
            chk("rvalid", 1'b1, v);
            chk("reg_value", exp[k], d);
        end
        pmbus_host_model_inst.wr(CMD_UV_ACTION, 16'h1234);
        pmbus_host_model_inst.rd(CMD_UV_ACTION, d, v);
        chk("action_byte", 16'h0034, d);
    endtask : test_regs

    // Boundary value must not alert; crossing must, and the alert stays until cleared
    task automatic test_warn(input logic [7:0] c, input logic [15:0] lim, input logic [15:0] v);
        pmbus_host_model_inst.wr(c, lim);
        vout = lim;
        repeat (3) @(negedge clk);
        chk("alert_at_limit", 1'b1, alert_n);
        vout = v;
        repeat (2) @(negedge clk);
        vout = 16'h2000;
        repeat (3) @(negedge clk);
        chk("alert_sticky", 1'b0, alert_n);
        a_clr = 1;
        @(negedge clk);
        a_clr = 0;
        repeat (2) @(negedge clk);
        chk("alert_cleared", 1'b1, alert_n);
    endtask : test_warn

    task automatic test_latch();
        pmbus_host_model_inst.wr(CMD_UV_FAULT, 16'h0800);
        pmbus_host_model_inst.wr(CMD_UV_ACTION, 16'h00c0);
        vout = 16'h0100;
        repeat (4) @(negedge clk);
        chk("no_fault_soft_start", 2'b10, {alert_n, latched});
        ss_done = 1;
        repeat (20) @(negedge clk);
        chk("latched_off", 4'b0100, {alert_n, latched, oe, hic});
        vout = 16'h2000;
        pmbus_host_model_inst.turn_on();
        repeat (2) @(negedge clk);
        chk("op_clear", 3'b101, {alert_n, latched, oe});
        vout = 16'h0100;
        repeat (3) @(negedge clk);
        vout = 16'h2000;
        ctrl_en = 0;
        repeat (2) @(negedge clk);
        ctrl_en = 1;
        repeat (3) @(negedge clk);
        chk("pin_clear", 2'b01, {latched, oe});
        // Power cycle: reset clears the latch and restores the limits
        vout = 16'h0100;
        repeat (3) @(negedge clk);
        chk("relatched", 2'b10, {latched, oe});
        vout = 16'h2000;
        rst = 1;
        repeat (2) @(negedge clk);
        chk("power_cycle_hold", 3'b100, {alert_n, latched, oe});
        rst = 0;
        @(negedge clk);
        chk("power_cycle_clear", 3'b101, {alert_n, latched, oe});
        pmbus_host_model_inst.wr(CMD_UV_FAULT, 16'h0800);
    endtask : test_latch

    task automatic run_fault(input int stop_n, output int n, output int hcyc);
        logic prev;
        n = 0;
        hcyc = 0;
        prev = 0;
        vout = 16'h0100;
        for (int i = 0; i < 4000 && !latched && n < stop_n; i++)
        begin
            @(negedge clk);
            if (hic && oe)
                chk("oe_in_hiccup", 1'b0, oe);
            hcyc += int'(hic);
            n += int'(hic && !prev);
            prev = hic;
        end
    endtask : run_fault

    task automatic test_hiccup(input logic [2:0] r, input logic [2:0] d);
        int n, hcyc;
        pmbus_host_model_inst.wr(CMD_UV_ACTION, {8'h00, MODE_HICCUP, r, d});
        run_fault(1000, n, hcyc);
        chk("attempts", 16'(1 << r), 16'(n));
        chk("off_cycles", 16'(n * (UNIT << d)), 16'(hcyc));
        chk("shut_off", 2'b10, {latched, oe});
        vout = 16'h2000;
        pmbus_host_model_inst.turn_on();
    endtask : test_hiccup

    task automatic test_forever();
        int n, hcyc;
        pmbus_host_model_inst.wr(CMD_UV_ACTION, {8'h00, MODE_HICCUP, RETRY_FOREVER, 3'b000});
        run_fault(80, n, hcyc);
        chk("keeps_retrying", 9'd80, {latched, 8'(n)});
        vout = 16'h2000;
        repeat (UNIT + 4) @(negedge clk);
        chk("back_to_run", 3'b001, {latched, hic, oe});
    endtask : test_forever

    initial
    begin
        repeat (16) @(negedge clk);
        chk("reset_outputs", 4'b1000, {alert_n, oe, latched, hic});
        rst = 0;
        @(negedge clk);
        test_regs();
        test_warn(CMD_OV_WARN, 16'h3000, 16'h3001);
        test_warn(CMD_UV_WARN, 16'h1000, 16'h0fff);
        pmbus_host_model_inst.wr(CMD_UV_WARN, RST_UV_WARN);
        test_latch();
        for (int r = 0; r < 7; r++)
            test_hiccup(3'(r), 3'(r % 3));
        test_hiccup(3'd0, 3'd7);
        test_forever();
        test_hiccup(3'd1, 3'd0);
        complete_run();
    end

    initial
    begin
        #400000;
        error_cnt++;
        $display("[FAIL] watchdog expected finish seen timeout");
        complete_run();
    end
endmodule : vout_fault_monitor_tb
